// >>> temp_ind_pkg.sv
// Package: constants and carrier types for the die temperature indicator control
package temp_ind_pkg;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_RANGE = 1'b0;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACQ_WAIT_US = 200;
   localparam int ACQ_WAIT_CYC = (ACQ_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [3:0] SENSOR_CHANNEL = 4'hc;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   typedef struct packed {
      logic sensor_enable_bit;
      logic sensor_range_select_bit;
   } sensor_cfg_t;

   typedef struct packed {
      logic power_on;
      logic high_range;
      logic low_range;
   } sensor_ctl_t;
endpackage : temp_ind_pkg

// >>> acq_timer.sv
// Acquisition wait timer: counts a settle interval after each restart
`timescale 1ns/10ps
`default_nettype none
module acq_timer #(
   parameter int WAIT_CYC = temp_ind_pkg::ACQ_WAIT_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control
   input wire logic restart_i,
   // Status
   output logic ready_o
);
   import temp_ind_pkg::*;

   logic [CNT_W-1:0] cnt_q;

   // ----------------------------------------
   // Down counter
   // ----------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (restart_i) begin
         cnt_q <= CNT_W'(WAIT_CYC);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CNT_W'(1);
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= !restart_i && (cnt_q <= CNT_W'(1));
      end
   end
endmodule : acq_timer
`default_nettype wire

// >>> temp_ind_ctrl.sv
// Top: die temperature indicator enable, range and converter channel control
`timescale 1ns/10ps
`default_nettype none
module temp_ind_ctrl (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Control register write
   input wire logic cfg_wr_i,
   input wire temp_ind_pkg::sensor_cfg_t cfg_i,
   // Converter side
   input wire logic [3:0] adc_chan_sel_i,
   input wire logic adc_conv_start_i,
   // Analog sensor controls
   output temp_ind_pkg::sensor_ctl_t sensor_ctl_o,
   output logic sensor_to_adc_o,
   // Status
   output temp_ind_pkg::sensor_cfg_t cfg_o,
   output logic acq_ready_o
);
   import temp_ind_pkg::*;

   sensor_cfg_t cfg_q;
   logic route_q;
   logic route_d;
   logic restart;
   logic timer_ready;
   logic [CNT_W-1:0] since_restart_q;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // True when the converter mux points at the sensor's reserved channel
   function automatic logic is_sensor_chan(input logic [3:0] chan);
      return chan == SENSOR_CHANNEL;
   endfunction : is_sensor_chan

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   // reset clears bits
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_q.sensor_enable_bit <= RST_ENABLE;
         cfg_q.sensor_range_select_bit <= RST_RANGE;
      end else if (cfg_wr_i) begin
         cfg_q <= cfg_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_o <= '0;
      end else if (cfg_wr_i) begin
         cfg_o <= cfg_i;
      end
   end

   // ----------------------------------------
   // Analog controls
   // ----------------------------------------
   // power gating
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sensor_ctl_o <= '0;
      end else begin
         sensor_ctl_o.power_on <= cfg_q.sensor_enable_bit;
         sensor_ctl_o.high_range <= cfg_q.sensor_enable_bit && cfg_q.sensor_range_select_bit;
         sensor_ctl_o.low_range <= cfg_q.sensor_enable_bit && !cfg_q.sensor_range_select_bit;
      end
   end

   // ----------------------------------------
   // Channel routing
   // ----------------------------------------
   // reserved channel
   assign route_d = is_sensor_chan(adc_chan_sel_i);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         route_q <= 1'b0;
      end else begin
         route_q <= route_d;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sensor_to_adc_o <= 1'b0;
      end else begin
         sensor_to_adc_o <= route_d && cfg_q.sensor_enable_bit;
      end
   end

   // ----------------------------------------
   // Acquisition wait status
   // ----------------------------------------
   // Ready is advisory only: conversions are never blocked
   // restart wait on selection, conversion or a write that sets the enable bit
   assign restart = (route_d && !route_q) || (route_q && adc_conv_start_i) ||
                    (cfg_wr_i && cfg_i.sensor_enable_bit && !cfg_q.sensor_enable_bit);

   acq_timer #(
      .WAIT_CYC(ACQ_WAIT_CYC)
   ) u_timer (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .restart_i(restart),
      .ready_o(timer_ready)
   );

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acq_ready_o <= 1'b0;
      end else begin
         acq_ready_o <= timer_ready && route_q && cfg_q.sensor_enable_bit && !restart;
      end
   end

   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   // Cycles since the last wait restart, saturating; used by the wait checks only
   // Reset leaves it at zero: every ready needs a restart first
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         since_restart_q <= '0;
      end else if (restart) begin
         since_restart_q <= '0;
      end else if (since_restart_q != '1) begin
         since_restart_q <= since_restart_q + CNT_W'(1);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_power_follows_en: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sensor_ctl_o.power_on == $past(cfg_q.sensor_enable_bit))
      else $error("sensor power does not follow enable bit");
   chk_off_no_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !sensor_ctl_o.power_on |-> !sensor_ctl_o.high_range && !sensor_ctl_o.low_range)
      else $error("range drive active while sensor off");
   chk_high_range_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_wr_i && cfg_i.sensor_enable_bit && cfg_i.sensor_range_select_bit |=> ##1 sensor_ctl_o.high_range)
      else $error("high range not selected");
   chk_low_range_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_wr_i && cfg_i.sensor_enable_bit && !cfg_i.sensor_range_select_bit |=> ##1 sensor_ctl_o.low_range)
      else $error("low range not selected");
   chk_route_channel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sensor_to_adc_o |-> $past(adc_chan_sel_i) == SENSOR_CHANNEL)
      else $error("sensor routed to wrong channel");
   chk_select_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      route_d && !route_q |=> !acq_ready_o [*8])
      else $error("ready too soon after channel select");
   chk_conv_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      route_q && adc_conv_start_i |=> !acq_ready_o [*8])
      else $error("ready too soon after conversion");
   chk_reset_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !cfg_q.sensor_enable_bit && !cfg_q.sensor_range_select_bit)
      else $error("config not cleared by reset");
   chk_range_follows_hi: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sensor_ctl_o.high_range |-> $past(cfg_q.sensor_range_select_bit))
      else $error("high range drive without range bit");
   chk_range_follows_lo: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sensor_ctl_o.low_range |-> !$past(cfg_q.sensor_range_select_bit))
      else $error("low range drive with range bit set");
   chk_range_exclusive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      sensor_ctl_o.power_on |-> sensor_ctl_o.high_range != sensor_ctl_o.low_range)
      else $error("powered sensor without exactly one range");
   chk_cfg_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_wr_i |=> cfg_o == $past(cfg_i))
      else $error("control register readback wrong");

   // ----------------------------------------
   // Routing checks
   // ----------------------------------------
   chk_route_when_sel: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      is_sensor_chan(adc_chan_sel_i) && cfg_q.sensor_enable_bit |=> sensor_to_adc_o)
      else $error("sensor not routed to its channel");
   chk_off_no_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !cfg_q.sensor_enable_bit |=> !sensor_to_adc_o)
      else $error("sensor routed while disabled");

   // ----------------------------------------
   // Acquisition wait checks
   // ----------------------------------------
   // Ready may only rise one cycle after the timer's full count
   chk_ready_settled: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      acq_ready_o |-> since_restart_q > CNT_W'(ACQ_WAIT_CYC))
      else $error("ready before the acquisition wait elapsed");
   chk_ready_on_time: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(acq_ready_o) |-> since_restart_q == CNT_W'(ACQ_WAIT_CYC + 1))
      else $error("ready did not rise at the end of the wait");
   chk_ready_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      acq_ready_o && route_q && cfg_q.sensor_enable_bit && !restart |=> acq_ready_o)
      else $error("ready dropped without a restart");
   chk_timer_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      restart |=> !timer_ready)
      else $error("wait timer not restarted");
   chk_off_no_ready: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !cfg_q.sensor_enable_bit |=> !acq_ready_o)
      else $error("ready while sensor disabled");

   // ----------------------------------------
   // Reset checks
   // ----------------------------------------
   chk_reset_outputs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> !sensor_ctl_o.power_on && !sensor_to_adc_o && !acq_ready_o && cfg_o == '0)
      else $error("outputs not cleared by reset");
endmodule : temp_ind_ctrl
`default_nettype wire

// >>> adc_partner.sv
// Converter model: selects channels and starts conversions
`timescale 1ns/10ps
`default_nettype none
module adc_partner (
   // Clock and control
   input wire logic clock_i,
   input wire logic go_i,
   input wire logic [3:0] chan_i,
   input wire logic ready_i,
   // Converter requests
   output logic [3:0] sel_o,
   output logic start_o
);
   import temp_ind_pkg::*;
   logic [3:0] chan_q = 4'h0;
   logic go_q = 1'b0;
   int wait_q = 0;
   initial sel_o = 4'h0;
   initial start_o = 1'b0;
   // Bench requests taken on the rising edge, away from the falling-edge drive
   always @(posedge clock_i) begin
      chan_q <= chan_i;
      go_q <= go_i;
   end
   // own wait after selecting the sensor channel and after each conversion
   always @(negedge clock_i) begin
      sel_o <= chan_q;
      start_o <= go_q && ready_i && !start_o && wait_q == 0 && sel_o == SENSOR_CHANNEL;
      if (start_o || (chan_q == SENSOR_CHANNEL && sel_o != SENSOR_CHANNEL)) begin
         wait_q <= ACQ_WAIT_CYC;
      end else if (wait_q != 0) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule : adc_partner
`default_nettype wire

// >>> temp_ind_ctrl_tb.sv
// Self-checking bench for the die temperature indicator control
`timescale 1ns/10ps
`default_nettype none
module temp_ind_ctrl_tb;
   import temp_ind_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   sensor_cfg_t cfg_i = '0;
   logic [3:0] chan = 4'h0;
   logic go = 1'b0;
   logic [3:0] sel;
   logic start;
   sensor_ctl_t ctl;
   logic to_adc;
   sensor_cfg_t cfg_o;
   logic rdy;
   int bad_count = 0;
   int n_compared = 0;
   int n;
   logic [3:0] exp_q[$];
   event shown;
   initial forever #5 clock_i = ~clock_i;
   temp_ind_ctrl u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
      .adc_chan_sel_i(sel), .adc_conv_start_i(start), .sensor_ctl_o(ctl),
      .sensor_to_adc_o(to_adc), .cfg_o(cfg_o), .acq_ready_o(rdy));
   adc_partner u_adc (.clock_i(clock_i), .go_i(go), .chan_i(chan), .ready_i(rdy), .sel_o(sel), .start_o(start));
   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic end_of_test();
      $display("compared=%0d mismatches=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic wr(input sensor_cfg_t c, input logic [3:0] ch);
      logic e;
      e = c.sensor_enable_bit;
      chan = ch;
      cfg_i = c;
      cfg_wr_i = 1'b1;
      exp_q.push_back({e, e & c.sensor_range_select_bit, e & ~c.sensor_range_select_bit, e && ch == SENSOR_CHANNEL});
      @(negedge clock_i) cfg_wr_i = 1'b0;
      check({2'h0, cfg_o}, {2'h0, c});
      repeat (4) @(negedge clock_i);
      -> shown;
   endtask : wr
   always @(shown) check({ctl, to_adc}, exp_q.pop_front());
   initial begin
      repeat (3 * ACQ_WAIT_CYC) @(negedge clock_i);
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'ha7f4137a));
      repeat (8) @(negedge clock_i);
      rst_n_i = 1'b1;
      check({ctl, to_adc}, 4'h0);
      for (int i = 0; i < 4; i++) wr(sensor_cfg_t'(2'(i)), SENSOR_CHANNEL);
      for (int i = 0; i < 12; i++) wr(sensor_cfg_t'(2'($urandom)), 4'($urandom));
      wr(sensor_cfg_t'(2'h3), 4'h0);
      chan = SENSOR_CHANNEL;
      repeat (2) @(negedge clock_i);
      check({3'h0, rdy}, 4'h0);
      n = 2;
      while (rdy !== 1'b1 && n < 30000) begin
         @(negedge clock_i);
         n++;
      end
      check({3'h0, n > ACQ_WAIT_CYC && n <= ACQ_WAIT_CYC + 4}, 4'h1);
      go = 1'b1;
      while (start !== 1'b1) @(negedge clock_i);
      check({3'h0, rdy}, 4'h0);
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (start !== 1'b1 && n < 30000);
      check({3'h0, n > ACQ_WAIT_CYC && n <= ACQ_WAIT_CYC + 4}, 4'h1);
      check({3'h0, rdy}, 4'h0);
      go = 1'b0;
      rst_n_i = 1'b0;
      @(negedge clock_i);
      check({ctl, rdy}, 4'h0);
      check({2'h0, cfg_o}, 4'h0);
      check({3'h0, to_adc}, 4'h0);
      rst_n_i = 1'b1;
      wr(sensor_cfg_t'(2'h2), SENSOR_CHANNEL);
      @(negedge clock_i);
      end_of_test();
   end
endmodule : temp_ind_ctrl_tb
`default_nettype wire
